// *** rtl/ssp_defs.svh ***
// Constants for the serial programming port
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
`define SSP_WORD_BITS     24
`define SSP_ADDR_LSB      21
`define SSP_ADDR_A        3'h0
`define SSP_ADDR_B        3'h1
`define SSP_ADDR_C        3'h2
`define SSP_ADDR_D        3'h3
`define SSP_PAY_BITS      21
`define SSP_FRAC_BITS     8
`define SSP_WB_ADR_A      4'h0
`define SSP_WB_ADR_B      4'h4
`define SSP_WB_ADR_C      4'h8
`define SSP_WB_ADR_D      4'hc
`define SSP_WB_ADR_STAT   5'h10
`define SSP_WB_ADR_CTRL   5'h14
`define SSP_SYNC_DIV_RST  16'h0200
`define SSP_PINS_IDLE     3'h1
`endif

// *** rtl/ssp_pkg.sv ***
// Types for the serial programming port
package ssp_pkg;
  typedef struct packed {
    logic clk;
    logic data;
    logic strobe;
  } ssp_pins_t;
  typedef struct packed {
    logic [20:0] a_word;
    logic [20:0] b_word;
    logic [20:0] c_word;
    logic [20:0] d_word;
    logic [7:0]  frac_comp_current_setting;
  } ssp_work_t;
endpackage : ssp_pkg

// *** rtl/ssp_port.sv ***
// Serial programming port with working registers and a Wishbone view
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
`include "ssp_defs.svh"
// Operation
// R01 - Three lines, clock data strobe, program all device settings
// R02 - Each word is 24 bits with a three bit address field
// R03 - Strobe low: each rising serial clock shifts data into register
// R04 - Strobe high: serial clock blocked, shift register frozen
// R05 - Address bits route the payload to its own working register
// R06 - Host sends A, B and C words to configure synthesizers
// R07 - D word programs power control, offset divide, enables and sleep
// R08 - B word keeps compensation setting in a temporary holder only
// R09 - Loading A also moves held compensation setting into working
// R10 - A word reaches main divider registers only on sync pulse
// R11 - Main divider terminal count gives sync and phase detector pulse
// R12 - A load blocked per divider cycle for up to reference period
// R13 - Host holds strobe high long enough for an A load
// R14 - After A load both main pumps stay in speed-up while strobe high
// R15 - Words travel least significant bit first on leading clock edge
// R16 - Strobe rise moves shift register only when address decodes
// R17 - Host raises strobe half clock after the last bit edge
// R18 - At most one load per strobe high period
// R19 - Shift register keeps last 24 bits, address in top positions
// R20 - Pending A load stays armed until first sync while strobe high
// R21 - Host keeps serial clock at or below 10 MHz
module ssp_port #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Serial pins from host
  input  wire logic          ser_clk_i,
  input  wire logic          ser_data_i,
  input  wire logic          ser_strobe_i,
  // Main divider input pulses
  input  wire logic          vco_tick_i,
  // Wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [4:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // Device outputs
  output ssp_pkg::ssp_work_t work_o,
  output logic               main_pd_pulse_o,
  output logic               proportional_pump_output_o,
  output logic               integral_pump_output_o
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Strobe resets to its idle high level, so release gives no false rise
  ssp_pkg::ssp_pins_t pins;
  ssp_pkg::ssp_pins_t s1_ff, nxt_s1;
  ssp_pkg::ssp_pins_t s2_ff, nxt_s2;
  ssp_pkg::ssp_pins_t s3_ff, nxt_s3;
  assign pins = '{clk: ser_clk_i, data: ser_data_i, strobe: ser_strobe_i};
  always_comb begin
    nxt_s1 = pins;
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= `SSP_PINS_IDLE;
      s2_ff <= `SSP_PINS_IDLE;
      s3_ff <= `SSP_PINS_IDLE;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
    end
  end
  // Only the second stage and the edge register feed logic
  logic clk_rise;
  logic stb_rise;
  logic stb_high;
  logic ser_bit;
  assign clk_rise = s2_ff.clk & ~s3_ff.clk;
  assign stb_rise = s2_ff.strobe & ~s3_ff.strobe;
  assign stb_high = s2_ff.strobe;
  assign ser_bit  = s2_ff.data;

  // ---------------------------------------------------------------
  // Main divider and sync
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] div_ff, nxt_div;
  logic             sync;
  // Ratio from A word bits 15:0, clamped to the smallest legal value
  logic [DIV_W-1:0] ratio;
  logic [DIV_W-1:0] ratio_raw;
  logic [DIV_W-1:0] ratio_min;
  logic [DIV_W-1:0] last_cnt;
  assign ratio_raw = DIV_W'(work_o.a_word[15:0]);
  assign ratio_min = DIV_W'(`SSP_SYNC_DIV_RST);
  assign ratio     = (ratio_raw < ratio_min) ? ratio_min : ratio_raw;
  assign last_cnt  = ratio - DIV_W'(1);
  assign sync = vco_tick_i & (div_ff == last_cnt); // see R11
  always_comb begin
    nxt_div = div_ff;
    if (vco_tick_i) begin
      nxt_div = sync ? '0 : div_ff + DIV_W'(1); // see R12
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end
  assign main_pd_pulse_o = sync; // see R11

  // ---------------------------------------------------------------
  // Input shift register
  // ---------------------------------------------------------------
  logic [23:0] sr_ff, nxt_sr; // see R02, R19
  logic [2:0]  addr;
  logic [20:0] payload;
  assign addr    = sr_ff[23:`SSP_ADDR_LSB]; // see R19
  assign payload = sr_ff[`SSP_PAY_BITS-1:0];
  always_comb begin
    nxt_sr = sr_ff;
    // Clock path only open while strobe is low
    if (!stb_high && clk_rise) begin // see R03, R04
      nxt_sr = {ser_bit, sr_ff[23:1]}; // see R15
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sr_ff <= '0;
    end else begin
      sr_ff <= nxt_sr;
    end
  end

  // ---------------------------------------------------------------
  // Address decode and once per strobe guard
  // ---------------------------------------------------------------
  logic dec_a;
  logic dec_b;
  logic dec_c;
  logic dec_d;
  logic take;
  logic done_ff, nxt_done;
  assign dec_a = (addr == `SSP_ADDR_A); // see R05
  assign dec_b = (addr == `SSP_ADDR_B);
  assign dec_c = (addr == `SSP_ADDR_C);
  assign dec_d = (addr == `SSP_ADDR_D);
  // Stray decoder changes while strobe high cannot reload
  assign take  = stb_rise & ~done_ff; // see R16, R18
  always_comb begin
    nxt_done = done_ff;
    if (!stb_high) begin
      nxt_done = 1'b0;
    end else if (take) begin
      nxt_done = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
    end
  end

  // ---------------------------------------------------------------
  // Pending A word and compensation holder
  // ---------------------------------------------------------------
  logic [20:0] a_pend_ff, nxt_a_pend;
  logic        a_arm_ff, nxt_a_arm;
  logic [7:0]  frac_hold_ff, nxt_frac_hold;
  logic        a_apply;
  assign a_apply = a_arm_ff & stb_high & sync; // see R10, R20
  always_comb begin
    nxt_a_pend    = a_pend_ff;
    nxt_a_arm     = a_arm_ff;
    nxt_frac_hold = frac_hold_ff;
    if (!stb_high || a_apply) begin
      nxt_a_arm = 1'b0; // see R20
    end else if (take && dec_a) begin
      nxt_a_arm = 1'b1;
    end
    if (take && dec_a) begin
      nxt_a_pend = payload;
    end
    if (take && dec_b) begin
      nxt_frac_hold = payload[`SSP_FRAC_BITS-1:0]; // see R08
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_pend_ff    <= '0;
      a_arm_ff     <= 1'b0;
      frac_hold_ff <= '0;
    end else begin
      a_pend_ff    <= nxt_a_pend;
      a_arm_ff     <= nxt_a_arm;
      frac_hold_ff <= nxt_frac_hold;
    end
  end

  // ---------------------------------------------------------------
  // Working registers
  // ---------------------------------------------------------------
  ssp_pkg::ssp_work_t work_ff, nxt_work;
  always_comb begin
    nxt_work = work_ff;
    if (take && dec_b) begin // see R05
      nxt_work.b_word = payload;
    end
    if (take && dec_c) begin
      nxt_work.c_word = payload;
    end
    if (take && dec_d) begin
      nxt_work.d_word = payload; // see R07
    end
    // Divider and compensation change on one edge, no false step
    if (a_apply) begin
      nxt_work.a_word = a_pend_ff; // see R10
      nxt_work.frac_comp_current_setting = frac_hold_ff; // see R09
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      work_ff <= '0;
    end else begin
      work_ff <= nxt_work;
    end
  end
  assign work_o = work_ff; // see R01

  // ---------------------------------------------------------------
  // Charge pump speed-up
  // ---------------------------------------------------------------
  logic speed_ff, nxt_speed;
  always_comb begin
    nxt_speed = speed_ff;
    if (!stb_high) begin
      nxt_speed = 1'b0; // see R14
    end else if (a_apply) begin
      nxt_speed = 1'b1; // see R14
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_ff <= 1'b0;
    end else begin
      speed_ff <= nxt_speed;
    end
  end
  assign proportional_pump_output_o = speed_ff; // see R14
  assign integral_pump_output_o     = speed_ff;

  // ---------------------------------------------------------------
  // Strobe load counter
  // ---------------------------------------------------------------
  // Counts every taken strobe, undecoded addresses included
  logic [31:0] loads_ff, nxt_loads;
  always_comb begin
    nxt_loads = loads_ff;
    if (take) begin
      nxt_loads = loads_ff + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loads_ff <= '0;
    end else begin
      loads_ff <= nxt_loads;
    end
  end

  // ---------------------------------------------------------------
  // Wishbone slave, read only view, one wait state
  // ---------------------------------------------------------------
  logic [31:0] rd_ff, nxt_rd;
  logic        ack_ff, nxt_ack;
  always_comb begin
    nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
    nxt_rd  = rd_ff;
    if (nxt_ack) begin
      if (wb_adr_i == {1'b0, `SSP_WB_ADR_A}) begin
        nxt_rd = {11'h000, work_ff.a_word};
      end else if (wb_adr_i == {1'b0, `SSP_WB_ADR_B}) begin
        nxt_rd = {11'h000, work_ff.b_word};
      end else if (wb_adr_i == {1'b0, `SSP_WB_ADR_C}) begin
        nxt_rd = {11'h000, work_ff.c_word};
      end else if (wb_adr_i == {1'b0, `SSP_WB_ADR_D}) begin
        nxt_rd = {11'h000, work_ff.d_word};
      end else if (wb_adr_i == `SSP_WB_ADR_STAT) begin
        nxt_rd = {20'h00000, frac_hold_ff, stb_high, speed_ff, done_ff, a_arm_ff};
      end else if (wb_adr_i == `SSP_WB_ADR_CTRL) begin
        nxt_rd = loads_ff;
      end else begin
        nxt_rd = 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ff  <= '0;
      ack_ff <= 1'b0;
    end else begin
      rd_ff  <= nxt_rd;
      ack_ff <= nxt_ack;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_ff;
endmodule : ssp_port

// *** dv/ssp_port_asserts.sv ***
// Checker for the serial programming port
`timescale 1ns/100ps
module ssp_port_asserts (
  // Clock and reset
  input wire logic               clk_i,
  input wire logic               rst_i,
  // Watched ports
  input wire logic               ser_strobe_i,
  input wire logic               wb_ack_o,
  input wire ssp_pkg::ssp_work_t work_o,
  input wire logic               main_pd_pulse_o,
  input wire logic               proportional_pump_output_o,
  input wire logic               integral_pump_output_o
);
  wire pd = main_pd_pulse_o;
  wire pp = proportional_pump_output_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_pump_pair: assert property (pp == integral_pump_output_o)
    else $error("pumps differ");
  chk_pump_off: assert property (!ser_strobe_i [*6] |-> !pp)
    else $error("speed-up with strobe low");
  chk_a_sync: assert property ($changed(work_o.a_word) |-> $past(pd) || $past(pd, 2))
    else $error("a load off sync");
  chk_frac_sync: assert property ($changed(work_o.frac_comp_current_setting) |->
    $past(pd) || $past(pd, 2))
    else $error("frac load off sync");
  chk_a_strobe: assert property ($changed(work_o.a_word) |-> ser_strobe_i)
    else $error("a load strobe low");
  chk_bcd_strobe: assert property (
    $changed({work_o.b_word, work_o.c_word, work_o.d_word}) |-> ser_strobe_i)
    else $error("load strobe low");
  chk_pd_single: assert property (pd |=> !pd)
    else $error("sync pulse too long");
endmodule : ssp_port_asserts
bind ssp_port ssp_port_asserts u_ssp_port_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .ser_strobe_i(ser_strobe_i), .wb_ack_o(wb_ack_o), .work_o(work_o),
  .main_pd_pulse_o(main_pd_pulse_o), .proportional_pump_output_o(proportional_pump_output_o),
  .integral_pump_output_o(integral_pump_output_o));

// *** dv/ssp_host_model.sv ***
// Host model driving the serial programming lines
`timescale 1ns/100ps
module ssp_host_model (
  // Clock
  input  wire logic clk_i,
  // Serial lines
  output logic      ser_clk_o,
  output logic      ser_data_o,
  output logic      ser_strobe_o
);
  initial ser_clk_o = 1'b0;
  initial ser_data_o = 1'b0;
  initial ser_strobe_o = 1'b1;
  // 16 clk per bit gives 160 ns serial period
  task automatic send(input logic [23:0] w);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_i);
      ser_strobe_o <= 1'b0;
      ser_clk_o    <= 1'b0;
      ser_data_o   <= w[i];
      repeat (7) @(posedge clk_i);
      ser_clk_o <= 1'b1;
      repeat (8) @(posedge clk_i);
    end
    ser_clk_o    <= 1'b0;
    ser_strobe_o <= 1'b1;
    ser_data_o   <= ~w[23];
  endtask : send
  task automatic drop;
    @(posedge clk_i);
    ser_strobe_o <= 1'b0;
  endtask : drop
endmodule : ssp_host_model

// *** dv/testbench.sv ***
// Self-checking bench for the serial programming port
`timescale 1ns/100ps
module testbench;
  logic               clk_i = 1'b0, rst_i = 1'b1, tick = 1'b0;
  logic               wb_req = 1'b0, wb_we = 1'b0;
  logic [4:0]         wb_adr = 5'h00;
  logic [31:0]        rd, dat;
  logic               ack, pd, pp, ip, sck, sdat, sstb;
  ssp_pkg::ssp_work_t work;
  int                 error_cnt = 0, compares = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) tick <= ~tick;
  ssp_port u_ssp_port (.clk_i(clk_i), .rst_i(rst_i), .ser_clk_i(sck), .ser_data_i(sdat),
    .ser_strobe_i(sstb), .vco_tick_i(tick), .wb_cyc_i(wb_req), .wb_stb_i(wb_req),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(32'h0000005a),
    .wb_dat_o(dat), .wb_ack_o(ack), .work_o(work), .main_pd_pulse_o(pd),
    .proportional_pump_output_o(pp), .integral_pump_output_o(ip));
  ssp_host_model u_ssp_host_model (.clk_i(clk_i), .ser_clk_o(sck), .ser_data_o(sdat),
    .ser_strobe_o(sstb));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic bus(input logic we, input logic [4:0] adr);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat;
    wb_req <= 1'b0;
    if (ack !== 1'b1) begin
      error_cnt++;
      results();
    end
  endtask : bus
  task automatic t_words;
    logic [23:0] w [3] = '{{3'h1, 21'h1234c7}, {3'h2, 21'h0a5a5a}, {3'h3, 21'h1c3e01}};
    logic [62:0] bcd;
    for (int i = 0; i < 3; i++) begin
      u_ssp_host_model.send(w[i]);
      repeat (8) @(posedge clk_i);
      bcd = {work.b_word, work.c_word, work.d_word};
      chk(bcd[62-21*i -: 21], w[i][20:0]);
    end
    chk(work.frac_comp_current_setting, 8'h00);
    u_ssp_host_model.send({3'h7, 21'h1fffff});
    repeat (8) @(posedge clk_i);
    chk({work.a_word, work.b_word[2:0]}, 24'h000007);
    bus(1'b1, 5'h04);
    bus(1'b0, 5'h04);
    chk(rd, 32'h001234c7);
    bus(1'b0, 5'h10);
    chk(rd[11:4], 8'hc7);
    $display("test words done");
  endtask : t_words
  task automatic t_a;
    int n;
    n = 0;
    u_ssp_host_model.send({3'h0, 21'h150200});
    while (pp !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (pp !== 1'b1) begin
      error_cnt++;
      results();
    end
    chk(work.a_word, 21'h150200);
    chk(work.frac_comp_current_setting, 8'hc7);
    repeat (100) @(posedge clk_i);
    chk({pp, ip}, 2'b11);
    u_ssp_host_model.drop();
    repeat (10) @(posedge clk_i);
    chk({pp, ip}, 2'b00);
    bus(1'b0, 5'h14);
    chk(rd, 32'h00000005);
    // Ratio 512 with a tick every other clock gives 1024 clocks
    n = 0;
    while (pd !== 1'b1 && n < 1100) begin
      @(posedge clk_i);
      n++;
    end
    if (pd !== 1'b1) begin
      error_cnt++;
      results();
    end
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pd !== 1'b1 && n < 1100);
    chk(n, 32'h00000400);
    $display("test a word done");
  endtask : t_a
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    bus(1'b0, 5'h18);
    chk(rd, 32'h00000000);
    t_words();
    t_a();
    results();
  end
endmodule : testbench
